/* File: hdl/msr_rate_ctrl.sv */
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - Interrupt level follows int_active_high polarity.
// - Slave address acknowledge releases asserted interrupt.
// - Interrupts work under any auto mode.
// - Sleep timeout is 1 to 256 ticks.
// - Rate register at 0x08, cleared at reset.
// - Code 000 samples tap at 3846/s.
// - Tap keeps fast and slow averages.
// - Tap compares difference against tap threshold.
// - Code 000 averages 32 every 8.36 ms.
// - Codes 001-011 update at 15.625-62.5 ms.
// - Codes 100-111 update at 125-1000 ms.
// - Wake codes give 32, 16, 8, 1 per second.
// - Sleep limit reached switches to wake rate.
// - Prescale divides sleep clock by 16.
module msr_rate_ctrl
    import msr_pkg::*;
#(
    parameter int unsigned TAP_CYC      = CYC_TAP,
    parameter int unsigned RATE_CYC [8] = '{CYC_120, CYC_64, CYC_32, CYC_16,
                                            CYC_8, CYC_4, CYC_2, CYC_1}
)
(
    // Clock and reset.
    input  wire logic              ref_clk_i,
    input  wire logic              rst_n_i,
    // Register port from the serial front end.
    input  wire logic              reg_wr_i,
    input  wire logic              reg_rd_i,
    input  wire logic        [7:0] reg_addr_i,
    input  wire logic        [7:0] reg_wdata_i,
    input  wire logic              addr_ack_i,
    output logic             [7:0] reg_rdata_o,
    // Raw converter samples and outside interrupt sources.
    input  wire logic signed [5:0] raw_x_i,
    input  wire logic signed [5:0] raw_y_i,
    input  wire logic signed [5:0] raw_z_i,
    input  wire logic              event_i,
    // Averaged results and events.
    output logic signed      [5:0] x_axis_result_o,
    output logic signed      [5:0] y_axis_result_o,
    output logic signed      [5:0] z_axis_result_o,
    output logic                   result_upd_o,
    output logic                   tap_o,
    // Interrupt pin.
    output logic                   int_o,
    output logic                   int_oe_o
);

    // Wake rate codes map onto the matching active rate periods.
    function automatic logic [2:0] wake_idx(input logic [1:0] code);
        logic [2:0] idx;
        unique case (code)
            2'h0: idx = 3'h2;
            2'h1: idx = 3'h3;
            2'h2: idx = 3'h4;
            2'h3: idx = 3'h7;
        endcase
        return idx;
    endfunction : wake_idx

    logic              [7:0] rate_cfg;
    logic              [7:0] mode_cfg;
    logic              [7:0] sleep_count_limit;
    logic              [4:0] tap_delta_threshold;
    logic              [7:0] next_rate;
    logic              [7:0] next_mode;
    logic              [7:0] next_sleep_lim;
    logic              [4:0] next_tap_thr;
    logic              [7:0] next_rdata;
    msr_state_t              state;
    msr_state_t              next_state;
    logic             [19:0] sub_cnt;
    logic             [19:0] next_sub_cnt;
    logic             [19:0] sub_len;
    logic              [4:0] samp_idx;
    logic              [4:0] next_samp_idx;
    logic signed      [10:0] acc [3];
    logic signed      [10:0] next_acc [3];
    logic signed      [10:0] sum [3];
    logic signed       [5:0] res [3];
    logic signed       [5:0] next_res [3];
    logic signed       [5:0] raw [3];
    logic                    next_upd;
    logic             [12:0] tap_cnt;
    logic             [12:0] next_tap_cnt;
    logic                    tap_tick;
    logic                    next_tap_tick;
    logic              [3:0] pre_cnt;
    logic              [3:0] next_pre_cnt;
    logic              [7:0] sleep_cnt;
    logic              [7:0] next_sleep_cnt;
    logic                    irq;
    logic                    next_irq;
    logic                    next_int;
    logic                    next_int_oe;
    logic                    level;
    logic              [2:0] hit;
    logic                    tap_hit;
    logic                    standby;
    logic                    running;
    logic                    mode_wr;
    logic                    slp_rst;
    logic                    restart;
    logic              [2:0] cur_code;
    logic                    samp;
    logic                    publish;
    logic                    tap_mode;
    logic                    slp_pub;
    logic                    slp_tick;
    logic                    sleep_expire;
    logic                    int_evt;

    assign raw[0]          = raw_x_i;
    assign raw[1]          = raw_y_i;
    assign raw[2]          = raw_z_i;
    assign x_axis_result_o = res[0];
    assign y_axis_result_o = res[1];
    assign z_axis_result_o = res[2];

    // Shared decode of the current operating point.
    assign standby  = state == ST_STANDBY;
    assign running  = !standby;
    assign mode_wr  = reg_wr_i && reg_addr_i == ADDR_MODE;
    assign tap_hit  = |hit;
    assign int_evt  = running && (event_i || tap_hit);
    assign tap_mode = state == ST_RUN
                      && rate_cfg[2:0] == RATE_120_TAP_CODE;
    // Writing the sleep limit or touching the mode register, and any
    // interrupt activity, restart sleep timing.
    assign slp_rst  = (reg_wr_i && reg_addr_i == ADDR_SLEEP)
                      || ((reg_wr_i || reg_rd_i) && reg_addr_i == ADDR_MODE)
                      || int_evt;

    // Configuration is only changed in standby, so the rate logic never
    // sees a half-updated setting; the mode register is always writable.
    always_comb begin
        next_rate      = rate_cfg;
        next_mode      = mode_cfg;
        next_sleep_lim = sleep_count_limit;
        next_tap_thr   = tap_delta_threshold;
        if (mode_wr) begin
            next_mode = reg_wdata_i & MODE_MASK;
        end
        if (reg_wr_i && standby) begin
            unique case (reg_addr_i)
                ADDR_RATE:  next_rate = reg_wdata_i;
                ADDR_SLEEP: next_sleep_lim = reg_wdata_i;
                ADDR_TAP:   next_tap_thr = reg_wdata_i[4:0];
                default:    next_rate = rate_cfg;
            endcase
        end
        unique case (reg_addr_i)
            ADDR_X:     next_rdata = {{2{res[0][5]}}, res[0]};
            ADDR_Y:     next_rdata = {{2{res[1][5]}}, res[1]};
            ADDR_Z:     next_rdata = {{2{res[2][5]}}, res[2]};
            ADDR_STAT:  next_rdata = {6'h00, state == ST_WAKE,
                                      state == ST_RUN};
            ADDR_SLEEP: next_rdata = sleep_count_limit;
            ADDR_MODE:  next_rdata = mode_cfg;
            ADDR_RATE:  next_rdata = rate_cfg;
            ADDR_TAP:   next_rdata = {3'h0, tap_delta_threshold};
            default:    next_rdata = 8'h00;
        endcase
        if (!reg_rd_i) begin
            next_rdata = reg_rdata_o;
        end
    end

    // Configuration registers and read data.
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rate_cfg            <= RATE_RST;
            mode_cfg            <= MODE_RST;
            sleep_count_limit   <= SLEEP_RST;
            tap_delta_threshold <= TAP_RST;
            reg_rdata_o         <= 8'h00;
        end else begin
            rate_cfg            <= next_rate;
            mode_cfg            <= next_mode;
            sleep_count_limit   <= next_sleep_lim;
            tap_delta_threshold <= next_tap_thr;
            reg_rdata_o         <= next_rdata;
        end
    end

    // Rate in use: wake rate during auto-wake, else the active rate.
    assign cur_code = (state == ST_WAKE)
                      ? wake_idx(rate_cfg[RATE_WAKE_LSB +: 2])
                      : rate_cfg[2:0];
    // Each update is 32 samples spread over the period.
    assign sub_len  = 20'(RATE_CYC[cur_code] >> AVG_SHIFT);
    assign samp     = running && (21'(sub_cnt) + 21'h1 >= 21'(sub_len));
    assign publish  = samp && samp_idx == AVG_LAST;
    // Sleep counter ticks on updates, optionally divided by 16.
    assign slp_pub  = state == ST_RUN && mode_cfg[MODE_SLEEP_BIT] && publish;
    assign slp_tick = slp_pub && (!mode_cfg[MODE_PRESC_BIT]
                                  || pre_cnt == PRESCALE_LAST);
    // A limit of zero wraps the 8-bit compare, giving 256 ticks.
    assign sleep_expire = slp_tick
                          && 8'(sleep_cnt + 8'h01) == sleep_count_limit;
    assign restart  = next_state != state;

    // Operating state, averaging, tap timing and sleep counting.
    always_comb begin
        next_state = state;
        unique case (state)
            ST_STANDBY: begin
                if (mode_cfg[MODE_ACT_BIT]) next_state = ST_RUN;
            end
            ST_RUN: begin
                if (!mode_cfg[MODE_ACT_BIT]) next_state = ST_STANDBY;
                else if (sleep_expire) next_state = ST_WAKE;
            end
            ST_WAKE: begin
                if (!mode_cfg[MODE_ACT_BIT]) next_state = ST_STANDBY;
                else if (int_evt && mode_cfg[MODE_WAKE_BIT]) begin
                    next_state = ST_RUN;
                end
            end
        endcase
        next_sub_cnt  = (!running || restart || samp) ? 20'h0_0000
                                                      : sub_cnt + 20'h0_0001;
        next_samp_idx = samp_idx;
        if (!running || restart) next_samp_idx = 5'h00;
        else if (samp) next_samp_idx = samp_idx + 5'h01;
        for (int i = 0; i < 3; i++) begin
            sum[i]      = acc[i] + 11'(raw[i]);
            next_acc[i] = acc[i];
            next_res[i] = res[i];
            if (!running || restart) begin
                next_acc[i] = 11'h000;
            end else if (publish) begin
                next_acc[i] = 11'h000;
                next_res[i] = sum[i][10:5];
            end else if (samp) begin
                next_acc[i] = sum[i];
            end
            if (mode_wr) next_res[i] = 6'h00;
        end
        next_upd      = publish;
        next_tap_tick = tap_mode && tap_cnt == 13'(TAP_CYC - 1);
        next_tap_cnt  = (!tap_mode || next_tap_tick) ? 13'h0000
                                                     : tap_cnt + 13'h0001;
        next_pre_cnt  = pre_cnt;
        next_sleep_cnt = sleep_cnt;
        if (slp_rst || restart) begin
            next_pre_cnt   = 4'h0;
            next_sleep_cnt = 8'h00;
        end else begin
            if (slp_pub) next_pre_cnt = pre_cnt + 4'h1;
            if (slp_tick) next_sleep_cnt = sleep_cnt + 8'h01;
        end
    end

    // Timing state.
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state        <= ST_STANDBY;
            sub_cnt      <= 20'h0_0000;
            samp_idx     <= 5'h00;
            acc          <= '{3{11'h000}};
            res          <= '{3{6'h00}};
            result_upd_o <= 1'b0;
            tap_cnt      <= 13'h0000;
            tap_tick     <= 1'b0;
            pre_cnt      <= 4'h0;
            sleep_cnt    <= 8'h00;
        end else begin
            state        <= next_state;
            sub_cnt      <= next_sub_cnt;
            samp_idx     <= next_samp_idx;
            acc          <= next_acc;
            res          <= next_res;
            result_upd_o <= next_upd;
            tap_cnt      <= next_tap_cnt;
            tap_tick     <= next_tap_tick;
            pre_cnt      <= next_pre_cnt;
            sleep_cnt    <= next_sleep_cnt;
        end
    end

    // One tap filter per axis, refreshed on the fast tick.
    for (genvar g = 0; g < 3; g++) begin : g_axis
        msr_tap_axis u_axis (
            .ref_clk_i (ref_clk_i),
            .rst_n_i   (rst_n_i),
            .tick_i    (tap_tick),
            .clear_i   (!tap_mode),
            .raw_i     (raw[g]),
            .thr_i     (tap_delta_threshold),
            .hit_o     (hit[g])
        );
    end

    // A new event wins over a release in the same cycle, so none is lost.
    always_comb begin
        next_irq = irq;
        if (int_evt) next_irq = 1'b1;
        else if (addr_ack_i) next_irq = 1'b0;
        level = next_irq ? mode_cfg[MODE_POL_BIT]
                         : !mode_cfg[MODE_POL_BIT];
        // Open drain drives only the low level and floats the high one.
        next_int    = mode_cfg[MODE_IPP_BIT] ? level : 1'b0;
        next_int_oe = mode_cfg[MODE_IPP_BIT] ? 1'b1 : !level;
    end

    // Interrupt state and pin.
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            irq      <= 1'b0;
            int_o    <= 1'b0;
            int_oe_o <= 1'b0;
            tap_o    <= 1'b0;
        end else begin
            irq      <= next_irq;
            int_o    <= next_int;
            int_oe_o <= next_int_oe;
            tap_o    <= tap_hit;
        end
    end

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);

    chk_int_level: assert property (
        mode_cfg[MODE_IPP_BIT] && $stable(mode_cfg)
        |-> int_o == (irq ? mode_cfg[MODE_POL_BIT]
                          : !mode_cfg[MODE_POL_BIT]))
        else $error("interrupt pin level has wrong polarity");
    chk_int_release: assert property (
        irq && addr_ack_i && !int_evt |=> !irq)
        else $error("interrupt not released on address acknowledge");
    chk_int_set: assert property (
        int_evt |=> irq)
        else $error("interrupt event did not assert interrupt");
    chk_int_hold: assert property (
        irq && !addr_ack_i |=> irq)
        else $error("interrupt dropped before release");
    chk_rate_write: assert property (
        reg_wr_i && reg_addr_i == ADDR_RATE && standby
        |=> rate_cfg == $past(reg_wdata_i))
        else $error("rate register write lost");
    chk_tap_gap: assert property (
        tap_tick |=> !tap_tick [*8])
        else $error("tap ticks too close");
    chk_avg_done: assert property (
        publish && !restart |=> result_upd_o && samp_idx == 5'h00)
        else $error("update not after 32 samples");
    chk_sleep_exit: assert property (
        state == ST_RUN && sleep_expire && mode_cfg[MODE_ACT_BIT]
        |=> state == ST_WAKE)
        else $error("sleep limit did not switch to wake rate");
    chk_prescale: assert property (
        slp_tick && mode_cfg[MODE_PRESC_BIT] |-> pre_cnt == PRESCALE_LAST)
        else $error("prescaled sleep tick off the divide by 16");

    cov_sleep_wake: cover property (state == ST_RUN ##1 state == ST_WAKE);
    cov_int_cycle:  cover property (irq ##1 !irq);
    cov_tap:        cover property (tap_o && irq);

endmodule : msr_rate_ctrl
`default_nettype wire

/* File: shared/msr_pkg.sv */
`default_nettype none
package msr_pkg;

    // Register offsets on the serial register port.
    localparam logic [7:0] ADDR_X     = 8'h00;
    localparam logic [7:0] ADDR_Y     = 8'h01;
    localparam logic [7:0] ADDR_Z     = 8'h02;
    localparam logic [7:0] ADDR_STAT  = 8'h04;
    localparam logic [7:0] ADDR_SLEEP = 8'h05;
    localparam logic [7:0] ADDR_MODE  = 8'h07;
    localparam logic [7:0] ADDR_RATE  = 8'h08;
    localparam logic [7:0] ADDR_TAP   = 8'h09;

    // Field positions in the mode and sample rate registers.
    localparam int MODE_POL_BIT   = 7;
    localparam int MODE_IPP_BIT   = 6;
    localparam int MODE_PRESC_BIT = 5;
    localparam int MODE_SLEEP_BIT = 4;
    localparam int MODE_WAKE_BIT  = 3;
    localparam int MODE_ACT_BIT   = 0;
    localparam int RATE_WAKE_LSB  = 3;
    localparam int RATE_DEB_LSB   = 5;

    // Values after reset; bit 1 of the mode register is reserved.
    localparam logic [7:0] RATE_RST  = 8'h00;
    localparam logic [7:0] MODE_RST  = 8'h00;
    localparam logic [7:0] SLEEP_RST = 8'h00;
    localparam logic [4:0] TAP_RST   = 5'h00;
    localparam logic [7:0] MODE_MASK = 8'hFD;

    // Active rate codes.
    localparam logic [2:0] RATE_120_TAP_CODE = 3'h0;
    localparam logic [2:0] RATE_64_CODE      = 3'h1;
    localparam logic [2:0] RATE_32_CODE      = 3'h2;
    localparam logic [2:0] RATE_16_CODE      = 3'h3;

    // Clock period and update periods in their own units.
    localparam int unsigned CLK_PERIOD_NS = 40;
    localparam int unsigned T_TAP_US  = 260;
    localparam int unsigned T_120_US  = 8360;
    localparam int unsigned T_64_US   = 15625;
    localparam int unsigned T_32_US   = 31250;
    localparam int unsigned T_16_US   = 62500;
    localparam int unsigned T_8_US    = 125000;
    localparam int unsigned T_4_US    = 250000;
    localparam int unsigned T_2_US    = 500000;
    localparam int unsigned T_1_US    = 1000000;

    // Nominal periods round down to whole cycles.
    function automatic int unsigned us_to_cyc(input int unsigned us);
        return us * 1000 / CLK_PERIOD_NS;
    endfunction : us_to_cyc

    localparam int unsigned CYC_TAP = us_to_cyc(T_TAP_US);
    localparam int unsigned CYC_120 = us_to_cyc(T_120_US);
    localparam int unsigned CYC_64  = us_to_cyc(T_64_US);
    localparam int unsigned CYC_32  = us_to_cyc(T_32_US);
    localparam int unsigned CYC_16  = us_to_cyc(T_16_US);
    localparam int unsigned CYC_8   = us_to_cyc(T_8_US);
    localparam int unsigned CYC_4   = us_to_cyc(T_4_US);
    localparam int unsigned CYC_2   = us_to_cyc(T_2_US);
    localparam int unsigned CYC_1   = us_to_cyc(T_1_US);

    // Averaging depth of 32 and sleep prescale of 16.
    localparam int         AVG_SHIFT     = 5;
    localparam logic [4:0] AVG_LAST      = 5'h1F;
    localparam logic [3:0] PRESCALE_LAST = 4'hF;

    typedef enum logic [1:0] {ST_STANDBY, ST_RUN, ST_WAKE} msr_state_t;

endpackage : msr_pkg
`default_nettype wire

/* File: hdl/msr_tap_axis.sv */
`timescale 1ns/100ps
`default_nettype none
module msr_tap_axis
    import msr_pkg::*;
(
    // Clock and reset.
    input  wire logic              ref_clk_i,
    input  wire logic              rst_n_i,
    // Refresh strobe and filter clear.
    input  wire logic              tick_i,
    input  wire logic              clear_i,
    // Raw sample and threshold.
    input  wire logic signed [5:0] raw_i,
    input  wire logic        [4:0] thr_i,
    // One-cycle hit after a refresh.
    output logic                   hit_o
);

    logic signed [7:0] prev;
    logic signed [7:0] slow;
    logic signed [7:0] fast;
    logic signed [7:0] delta;
    logic        [7:0] mag;
    logic signed [7:0] next_prev;
    logic signed [7:0] next_slow;
    logic              next_hit;

    // Fast response averages this and the last sample; slow one lags by 8.
    always_comb begin
        fast      = (8'(raw_i) + prev) >>> 1;
        delta     = fast - slow;
        mag       = delta[7] ? 8'(-delta) : 8'(delta);
        next_prev = prev;
        next_slow = slow;
        next_hit  = 1'b0;
        if (clear_i) begin
            next_prev = 8'h00;
            next_slow = 8'h00;
        end else if (tick_i) begin
            next_prev = 8'(raw_i);
            next_slow = slow + (delta >>> 3);
            next_hit  = mag > {3'h0, thr_i};
        end
    end

    // Filter state.
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            prev  <= 8'h00;
            slow  <= 8'h00;
            hit_o <= 1'b0;
        end else begin
            prev  <= next_prev;
            slow  <= next_slow;
            hit_o <= next_hit;
        end
    end

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);

    chk_tap_compare: assert property (
        tick_i && !clear_i && mag > {3'h0, thr_i} |=> hit_o)
        else $error("tap hit missed above threshold");
    chk_tap_refresh: assert property (
        !tick_i |=> !hit_o)
        else $error("tap hit without a refresh");
    cov_tap_hit: cover property (tick_i ##1 hit_o);

endmodule : msr_tap_axis
`default_nettype wire

/* File: test/msr_host_model.sv */
`timescale 1ns/100ps
`default_nettype none
module msr_host_model (
    // Clock.
    input  wire logic       ref_clk_i,
    // Strobe port toward the block.
    output logic            reg_wr_o,
    output logic            reg_rd_o,
    output logic      [7:0] reg_addr_o,
    output logic      [7:0] reg_wdata_o,
    output logic            addr_ack_o,
    input  wire logic [7:0] reg_rdata_i
);
    // Idle at time zero; every change lands on a falling edge.
    initial begin
        reg_wr_o    = 1'b0;
        reg_rd_o    = 1'b0;
        reg_addr_o  = 8'h00;
        reg_wdata_o = 8'h00;
        addr_ack_o  = 1'b0;
    end
    // Released fields are inverted so a stale value is never reused.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge ref_clk_i);
        reg_addr_o  = a;
        reg_wdata_o = d;
        reg_wr_o    = 1'b1;
        @(negedge ref_clk_i);
        reg_wr_o    = 1'b0;
        reg_addr_o  = ~a;
        reg_wdata_o = ~d;
    endtask : wr
    // Read data is taken one edge after the strobe was accepted.
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge ref_clk_i);
        reg_addr_o = a;
        reg_rd_o   = 1'b1;
        @(negedge ref_clk_i);
        reg_rd_o   = 1'b0;
        reg_addr_o = ~a;
        d          = reg_rdata_i;
    endtask : rd
    // Address acknowledge of a transfer aimed at this device.
    task automatic ack();
        @(negedge ref_clk_i);
        addr_ack_o = 1'b1;
        @(negedge ref_clk_i);
        addr_ack_o = 1'b0;
    endtask : ack
endmodule : msr_host_model
`default_nettype wire

/* File: test/msr_rate_ctrl_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module msr_rate_ctrl_tb_top
    import msr_pkg::*;
;
    localparam int unsigned TAP_T = 20;
    localparam int unsigned RC [8] = '{64, 96, 128, 160, 192, 224, 256, 288};
    // Wake codes give 32, 16, 8 and 1 updates per second.
    localparam int unsigned WAKE_RC [4] = '{RC[2], RC[3], RC[4], RC[7]};
    logic              ref_clk_i, rst_n_i, wr, rd, ack, ev, upd, tap, pin, oe;
    logic        [7:0] addr, wdata, rdata, d;
    logic signed [5:0] rx, ry, rz, xo, yo, zo;
    int                n_fail = 0, n_compared = 0, n;
    msr_host_model host_u (.ref_clk_i(ref_clk_i), .reg_wr_o(wr),
        .reg_rd_o(rd), .reg_addr_o(addr), .reg_wdata_o(wdata),
        .addr_ack_o(ack), .reg_rdata_i(rdata));
    msr_rate_ctrl #(.TAP_CYC(TAP_T), .RATE_CYC(RC)) dut_u (
        .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .reg_wr_i(wr),
        .reg_rd_i(rd), .reg_addr_i(addr), .reg_wdata_i(wdata),
        .addr_ack_i(ack), .reg_rdata_o(rdata), .raw_x_i(rx), .raw_y_i(ry),
        .raw_z_i(rz), .event_i(ev), .x_axis_result_o(xo),
        .y_axis_result_o(yo), .z_axis_result_o(zo), .result_upd_o(upd),
        .tap_o(tap), .int_o(pin), .int_oe_o(oe));
    // Free-running 25 MHz clock.
    initial begin
        ref_clk_i = 1'b0;
        forever #20 ref_clk_i = ~ref_clk_i;
    end
    task automatic complete_run();
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : complete_run
    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t got %h exp %h", $time, got, exp);
        end
    endtask : cmp8
    task automatic cmp_cnt(input int got, input int exp);
        n_compared++;
        if (got != exp) begin
            n_fail++;
            $display("unexpected at %0t got %h exp %h", $time, got, exp);
        end
    endtask : cmp_cnt
    // Bounded wait for an update (sel 0) or tap (sel 1) pulse.
    task automatic wait_for(input bit sel, output int c);
        c = 0;
        do begin
            @(negedge ref_clk_i);
            c++;
        end while ((sel ? tap : upd) !== 1'b1 && c < 4000);
        if (c >= 4000) begin
            n_fail++;
            complete_run();
        end
    endtask : wait_for
    // Reset value, read-back and an unmapped offset.
    task automatic t_regs();
        host_u.rd(ADDR_RATE, d);
        cmp8(d, RATE_RST);
        host_u.wr(ADDR_RATE, 8'hA5);
        host_u.rd(ADDR_RATE, d);
        cmp8(d, 8'hA5);
        host_u.rd(8'h03, d);
        cmp8(d, 8'h00);
    endtask : t_regs
    // Every active code: update spacing and averaged values.
    task automatic t_rates();
        rx = 6'sh05;
        ry = -6'sd3;
        rz = 6'sh20;
        for (int c = 0; c < 8; c++) begin
            host_u.wr(ADDR_RATE, 8'(c));
            host_u.wr(ADDR_MODE, 8'h01);
            wait_for(0, n);
            wait_for(0, n);
            cmp_cnt(n, RC[c]);
            cmp8({xo, yo[1:0]}, 8'h15);
            cmp8(8'(yo), 8'hFD);
            cmp8(8'(zo), 8'hE0);
            host_u.rd(ADDR_Y, d);
            cmp8(d, 8'hFD);
            host_u.wr(ADDR_MODE, 8'h00);
        end
    endtask : t_rates
    // Pin level while active and idle, for one mode setting.
    task automatic chk_pin(input logic drive, input logic lvl);
        cmp8({6'h00, pin, oe}, {6'h00, drive & lvl, drive | ~lvl});
    endtask : chk_pin
    // Polarity, drive kind and auto modes swept together.
    task automatic t_irq();
        logic pol, drive;
        for (int i = 0; i < 4; i++) begin
            pol   = i[0];
            drive = i[1];
            host_u.wr(ADDR_MODE, {pol, drive, 1'b0, drive, pol, 3'b001});
            @(negedge ref_clk_i);
            ev = 1'b1;
            @(negedge ref_clk_i);
            ev = 1'b0;
            @(negedge ref_clk_i);
            chk_pin(drive, pol);
            repeat (6) @(negedge ref_clk_i);
            chk_pin(drive, pol);
            host_u.ack();
            @(negedge ref_clk_i);
            chk_pin(drive, ~pol);
            host_u.wr(ADDR_MODE, 8'h00);
        end
    endtask : t_irq
    // Sleep timeout into each wake rate and an event back out, then the
    // prescaled timeout.
    task automatic t_sleep();
        host_u.wr(ADDR_SLEEP, 8'h02);
        for (int w = 0; w < 4; w++) begin
            host_u.wr(ADDR_RATE, {3'h0, 2'(w), 3'h1});
            host_u.wr(ADDR_MODE, 8'h19);
            wait_for(0, n);
            host_u.rd(ADDR_STAT, d);
            cmp8(d, 8'h01);
            wait_for(0, n);
            repeat (3) @(negedge ref_clk_i);
            host_u.rd(ADDR_STAT, d);
            cmp8(d, 8'h02);
            wait_for(0, n);
            wait_for(0, n);
            cmp_cnt(n, WAKE_RC[w]);
            @(negedge ref_clk_i);
            ev = 1'b1;
            @(negedge ref_clk_i);
            ev = 1'b0;
            host_u.rd(ADDR_STAT, d);
            cmp8(d, 8'h01);
            host_u.wr(ADDR_MODE, 8'h00);
        end
        host_u.wr(ADDR_SLEEP, 8'h01);
        host_u.wr(ADDR_MODE, 8'h31);
        repeat (15) wait_for(0, n);
        host_u.rd(ADDR_STAT, d);
        cmp8(d, 8'h01);
        wait_for(0, n);
        repeat (3) @(negedge ref_clk_i);
        host_u.rd(ADDR_STAT, d);
        cmp8(d, 8'h02);
        host_u.wr(ADDR_MODE, 8'h00);
    endtask : t_sleep
    // A step on one axis must beat a small threshold.
    task automatic t_tap();
        {rx, ry, rz} = '0;
        host_u.wr(ADDR_TAP, 8'h02);
        host_u.wr(ADDR_RATE, 8'h00);
        host_u.wr(ADDR_MODE, 8'h01);
        repeat (10 * TAP_T) @(negedge ref_clk_i);
        rx = 6'sh1F;
        wait_for(1, n);
        cmp_cnt(int'(n <= TAP_T + 2), 1);
    endtask : t_tap
    // Reset for two cycles, then the scenarios in order.
    initial begin
        rst_n_i = 1'b0;
        ev = 1'b0;
        {rx, ry, rz} = '0;
        repeat (2) @(posedge ref_clk_i);
        @(negedge ref_clk_i);
        rst_n_i = 1'b1;
        t_regs();
        t_rates();
        t_irq();
        t_sleep();
        t_tap();
        complete_run();
    end
endmodule : msr_rate_ctrl_tb_top
`default_nettype wire
